// ### rtl/dpac_pkg.sv
// shared constants and types of the debug port access control block
package dpac_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int ACQ_WINDOW_NS = 8000;
  // a longest time rounds down
  localparam int ACQ_CYC = ACQ_WINDOW_NS / CLK_PERIOD_NS;
  localparam logic [10:0] ACQ_CYC_W = 11'(ACQ_CYC);
  // ==========================================================
  // swd acquire key, an arbitrary pattern of our own
  localparam int ACQ_KEY_W = 16;
  localparam logic [15:0] ACQ_KEY = 16'hA5C3;
  // ==========================================================
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_IDENT = 4'h8;
  localparam logic [31:0] IDENT_VAL = 32'h0000_1234; // arbitrary value
  // ctrl fields
  localparam int CTRL_DOC_EN = 0;
  localparam int CTRL_PORT_DIS = 1;
  localparam int CTRL_SWV_EN = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // status fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_LOCK = 3;
  localparam int STAT_ACQ = 4;
  localparam int STAT_WIN = 5;
  localparam int STAT_DPS_LSB = 6;
  // ==========================================================
  // port select setting held in the nonvolatile latch
  localparam logic [1:0] DPS_JTAG4 = 2'h0;
  localparam logic [1:0] DPS_JTAG5 = 2'h1;
  localparam logic [1:0] DPS_SWD = 2'h2;
  localparam logic [1:0] DPS_OFF = 2'h3;
  // pins used per configuration
  localparam logic [2:0] PINS_NONE = 3'h0;
  localparam logic [2:0] PINS_SWV = 3'h1;
  localparam logic [2:0] PINS_SWD = 3'h2;
  localparam logic [2:0] PINS_SWD_SWV = 3'h3;
  localparam logic [2:0] PINS_JTAG4 = 3'h4;
  localparam logic [2:0] PINS_JTAG5 = 3'h5;
  // ==========================================================
  // test access port instructions
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_DEVRST = 4'h8;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [31:0] TAP_IDCODE = 32'h0000_0ACB; // arbitrary value
  localparam int BSR_W = 8;
  localparam int TLR_TMS_ONES = 5;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_JTAG4 = 2'b01,
    MODE_JTAG5 = 2'b10,
    MODE_SWD = 2'b11
  } dpac_mode_t;

  typedef enum logic [3:0] {
    TAP_TLR = 4'b0000,
    TAP_RTI = 4'b0001,
    TAP_SDR = 4'b0010,
    TAP_CDR = 4'b0011,
    TAP_SHDR = 4'b0100,
    TAP_E1DR = 4'b0101,
    TAP_PDR = 4'b0110,
    TAP_E2DR = 4'b0111,
    TAP_UDR = 4'b1000,
    TAP_SIR = 4'b1001,
    TAP_CIR = 4'b1010,
    TAP_SHIR = 4'b1011,
    TAP_E1IR = 4'b1100,
    TAP_PIR = 4'b1101,
    TAP_E2IR = 4'b1110,
    TAP_UIR = 4'b1111
  } dpac_tap_t;
endpackage

// ### rtl/dpac_tap_if.sv
// carrier between the port controller and its test access port
`timescale 1ns/100ps
interface dpac_tap_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic trst;
  logic en;
  logic tdo;
  logic tdo_en;
  logic rst_req;
  logic in_tlr;
  modport ctl (output tck_rise, tck_fall, tms, tdi, trst, en,
               input tdo, tdo_en, rst_req, in_tlr);
  modport tap (input tck_rise, tck_fall, tms, tdi, trst, en,
               output tdo, tdo_en, rst_req, in_tlr);
endinterface

// ### rtl/dpac_tap.sv
// boundary-scan test access port state machine and data registers
`timescale 1ns/100ps
module dpac_tap (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link side
  dpac_tap_if.tap t,
  // boundary scan cells
  input wire logic [7:0] bsr_in_i
);
  dpac_pkg::dpac_tap_t st_reg, st_next;
  logic [3:0] ir_reg, ir_next, irs_reg, irs_next;
  logic [31:0] dr_reg, dr_next;
  logic tdo_reg, tdo_next, oen_reg, oen_next, rq_reg, rq_next;
  logic [2:0] ones_reg;

  // ==========================================================
  // state walk on every test clock rise
  function automatic dpac_pkg::dpac_tap_t step(dpac_pkg::dpac_tap_t s, logic m);
    case (s)
      dpac_pkg::TAP_TLR: step = m ? dpac_pkg::TAP_TLR : dpac_pkg::TAP_RTI;
      dpac_pkg::TAP_RTI: step = m ? dpac_pkg::TAP_SDR : dpac_pkg::TAP_RTI;
      dpac_pkg::TAP_SDR: step = m ? dpac_pkg::TAP_SIR : dpac_pkg::TAP_CDR;
      dpac_pkg::TAP_CDR: step = m ? dpac_pkg::TAP_E1DR : dpac_pkg::TAP_SHDR;
      dpac_pkg::TAP_SHDR: step = m ? dpac_pkg::TAP_E1DR : dpac_pkg::TAP_SHDR;
      dpac_pkg::TAP_E1DR: step = m ? dpac_pkg::TAP_UDR : dpac_pkg::TAP_PDR;
      dpac_pkg::TAP_PDR: step = m ? dpac_pkg::TAP_E2DR : dpac_pkg::TAP_PDR;
      dpac_pkg::TAP_E2DR: step = m ? dpac_pkg::TAP_UDR : dpac_pkg::TAP_SHDR;
      dpac_pkg::TAP_UDR: step = m ? dpac_pkg::TAP_SDR : dpac_pkg::TAP_RTI;
      dpac_pkg::TAP_SIR: step = m ? dpac_pkg::TAP_TLR : dpac_pkg::TAP_CIR;
      dpac_pkg::TAP_CIR: step = m ? dpac_pkg::TAP_E1IR : dpac_pkg::TAP_SHIR;
      dpac_pkg::TAP_SHIR: step = m ? dpac_pkg::TAP_E1IR : dpac_pkg::TAP_SHIR;
      dpac_pkg::TAP_E1IR: step = m ? dpac_pkg::TAP_UIR : dpac_pkg::TAP_PIR;
      dpac_pkg::TAP_PIR: step = m ? dpac_pkg::TAP_E2IR : dpac_pkg::TAP_PIR;
      dpac_pkg::TAP_E2IR: step = m ? dpac_pkg::TAP_UIR : dpac_pkg::TAP_SHIR;
      dpac_pkg::TAP_UIR: step = m ? dpac_pkg::TAP_SDR : dpac_pkg::TAP_RTI;
      default: step = dpac_pkg::TAP_TLR;
    endcase
  endfunction

  // next state, shifts and capture; tdo changes on the falling test clock
  always_comb begin
    st_next = st_reg;
    ir_next = ir_reg;
    irs_next = irs_reg;
    dr_next = dr_reg;
    tdo_next = tdo_reg;
    oen_next = oen_reg;
    rq_next = 1'b0;
    if (!t.en || t.trst) begin
      st_next = dpac_pkg::TAP_TLR; // [R6]
      ir_next = dpac_pkg::IR_IDCODE;
      oen_next = 1'b0;
    end else if (t.tck_rise) begin
      st_next = step(st_reg, t.tms); // [R5] [R13]
      case (st_reg)
        dpac_pkg::TAP_TLR: ir_next = dpac_pkg::IR_IDCODE;
        dpac_pkg::TAP_CIR: irs_next = dpac_pkg::IR_IDCODE;
        dpac_pkg::TAP_SHIR: irs_next = {t.tdi, irs_reg[3:1]};
        dpac_pkg::TAP_UIR: ir_next = irs_reg;
        dpac_pkg::TAP_CDR: begin
          case (ir_reg)
            dpac_pkg::IR_IDCODE: dr_next = dpac_pkg::TAP_IDCODE;
            dpac_pkg::IR_EXTEST: dr_next = {24'h000000, bsr_in_i}; // [R9]
            default: dr_next = 32'h00000000;
          endcase
        end
        dpac_pkg::TAP_SHDR: begin
          case (ir_reg)
            dpac_pkg::IR_IDCODE: dr_next = {t.tdi, dr_reg[31:1]};
            dpac_pkg::IR_EXTEST: dr_next = {24'h000000, t.tdi, dr_reg[7:1]};
            default: dr_next = {31'h00000000, t.tdi};
          endcase
        end
        dpac_pkg::TAP_UDR: rq_next = (ir_reg == dpac_pkg::IR_DEVRST) && dr_reg[0]; // [R10]
        default: ;
      endcase
    end else if (t.tck_fall) begin
      oen_next = (st_reg == dpac_pkg::TAP_SHDR) || (st_reg == dpac_pkg::TAP_SHIR);
      tdo_next = (st_reg == dpac_pkg::TAP_SHIR) ? irs_reg[0] : dr_reg[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= dpac_pkg::TAP_TLR;
      ir_reg <= dpac_pkg::IR_IDCODE;
      irs_reg <= dpac_pkg::IR_IDCODE;
      dr_reg <= 32'h00000000;
      tdo_reg <= 1'b0;
      oen_reg <= 1'b0;
      rq_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ir_reg <= ir_next;
      irs_reg <= irs_next;
      dr_reg <= dr_next;
      tdo_reg <= tdo_next;
      oen_reg <= oen_next;
      rq_reg <= rq_next;
    end
  end

  assign t.tdo = tdo_reg;
  assign t.tdo_en = oen_reg;
  assign t.rst_req = rq_reg;
  assign t.in_tlr = (st_reg == dpac_pkg::TAP_TLR);

  // helper: rises seen with the mode pin held high
  always_ff @(posedge clk_i) begin
    if (rst_i || !t.en) begin
      ones_reg <= 3'h0;
    end else if (t.tck_rise) begin
      ones_reg <= !t.tms ? 3'h0 :
                  (ones_reg == 3'(dpac_pkg::TLR_TMS_ONES)) ? ones_reg : ones_reg + 3'h1;
    end
  end

  a_tms_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    (ones_reg == 3'(dpac_pkg::TLR_TMS_ONES)) |-> (st_reg == dpac_pkg::TAP_TLR))
    else $error("five tms ones did not reset the tap");
endmodule

// ### rtl/dpac_top.sv
// debug port access control: pin sampling, port select, swd acquire, registers
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/100ps
// Function
// R1: debug circuits off until firmware enables them
// R2: no outside path re-enables debug circuits
// R3: lockout disables every programming/debug/test port
// R4: pins used follow the active configuration
// R5: test access port per boundary-scan standard
// R6: four or five pins, test reset optional
// R7: host keeps test clock within rate limits
// R8: boundary-scan on by default, firmware may release
// R9: scan chains only through boundary-scan port
// R10: port reset register works unless ports disabled
// R11: default 4-wire, no test reset, mode pin input
// R12: mode pin bidirectional while swd acquires
// R13: host resets tap by mode-pin sequence
// R14: swd enabled only by key within 8 us
// R15: port select sampled from latch at reset
module dpac_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // nonvolatile latch outputs
  input wire logic [1:0] debug_port_select_setting_i,
  input wire logic lockout_i,
  // link pins
  input wire logic tck_i,
  input wire logic tms_i,
  output logic tms_o,
  output logic tms_oe_n_o,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  // trace and scan
  input wire logic trace_viewer_output_i,
  input wire logic [7:0] bsr_in_i,
  // device side
  output logic debug_on_chip_circuits_o,
  output logic gpio_release_o,
  output logic [2:0] pins_used_o,
  output logic sys_reset_req_o
);
  dpac_tap_if t ();
  dpac_pkg::dpac_mode_t mode_reg, mode_next;
  logic [2:0] ctrl_reg, ctrl_next;
  logic [1:0] dps_reg, dps_next;
  logic lock_reg, lock_next, init_reg, init_next;
  logic acq_reg, acq_next, ack_pend_reg, ack_pend_next;
  logic [10:0] win_reg, win_next;
  logic [15:0] key_reg, key_next;
  logic [31:0] rdat_reg, rdat_next;
  logic ack_reg, ack_next;
  logic tms_out_reg, tms_oen_reg, tdo_out_reg, tdo_oen_reg;
  logic tms_out_next, tms_oen_next, tdo_out_next, tdo_oen_next;
  logic gpio_reg, gpio_next, srst_reg, srst_next;
  logic doc_reg, doc_next;
  logic [2:0] pins_reg, pins_next;
  logic [3:0] s1_reg, s2_reg;
  logic tck_d_reg;
  logic win_open, port_on, wb_req;

  // ==========================================================
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      tck_d_reg <= 1'b0;
    end else begin
      s1_reg <= {!trst_n_i, tdi_i, tms_i, tck_i};
      s2_reg <= s1_reg;
      tck_d_reg <= s2_reg[0];
    end
  end

  // test clock edges found by the system clock; rate limit is the host's duty [R7]
  assign t.tck_rise = s2_reg[0] && !tck_d_reg;
  assign t.tck_fall = !s2_reg[0] && tck_d_reg;
  assign t.tms = s2_reg[1];
  assign t.tdi = s2_reg[2];
  assign t.trst = s2_reg[3] && (mode_reg == dpac_pkg::MODE_JTAG5); // [R6] [R11]
  assign t.en = (mode_reg == dpac_pkg::MODE_JTAG4) || (mode_reg == dpac_pkg::MODE_JTAG5); // [R9]

  dpac_tap u_tap (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .t(t),
    .bsr_in_i(bsr_in_i)
  );

  // ==========================================================
  // port selection, acquire window and swd key
  assign win_open = init_reg && (win_reg < dpac_pkg::ACQ_CYC_W);
  assign port_on = (mode_reg != dpac_pkg::MODE_OFF);

  function automatic dpac_pkg::dpac_mode_t dps_mode(logic [1:0] d);
    case (d)
      dpac_pkg::DPS_JTAG4: dps_mode = dpac_pkg::MODE_JTAG4;
      dpac_pkg::DPS_JTAG5: dps_mode = dpac_pkg::MODE_JTAG5;
      dpac_pkg::DPS_SWD: dps_mode = dpac_pkg::MODE_OFF; // swd waits for the key [R14]
      default: dps_mode = dpac_pkg::MODE_OFF;
    endcase
  endfunction

  always_comb begin
    init_next = 1'b1;
    dps_next = dps_reg;
    lock_next = lock_reg;
    mode_next = mode_reg;
    win_next = win_reg;
    key_next = key_reg;
    acq_next = acq_reg;
    ack_pend_next = ack_pend_reg;
    if (!init_reg) begin
      // latch outputs taken once, in the first cycle after release [R15]
      dps_next = debug_port_select_setting_i;
      lock_next = lockout_i;
      mode_next = lockout_i ? dpac_pkg::MODE_OFF : dps_mode(debug_port_select_setting_i); // [R3] [R11]
    end else begin
      if (win_open) begin
        win_next = win_reg + 11'h001;
      end
      if (win_open && t.tck_rise) begin
        key_next = {key_reg[14:0], t.tms};
      end
      // a late key is ignored; swd can be taken inside the window unless lockout is set [R14]
      if (win_open && !lock_reg && key_reg == dpac_pkg::ACQ_KEY && !acq_reg) begin
        acq_next = 1'b1;
        ack_pend_next = 1'b1;
        mode_next = dpac_pkg::MODE_SWD;
      end
      if (ack_pend_reg && t.tck_rise) begin
        ack_pend_next = 1'b0;
      end
      if (ctrl_reg[dpac_pkg::CTRL_PORT_DIS] || lock_reg) begin
        mode_next = dpac_pkg::MODE_OFF; // [R8] [R3]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_reg <= 1'b0;
      dps_reg <= dpac_pkg::DPS_JTAG4;
      lock_reg <= 1'b1; // closed until the latch is read
      mode_reg <= dpac_pkg::MODE_OFF;
      win_reg <= 11'h000;
      key_reg <= 16'h0000;
      acq_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
    end else begin
      init_reg <= init_next;
      dps_reg <= dps_next;
      lock_reg <= lock_next;
      mode_reg <= mode_next;
      win_reg <= win_next;
      key_reg <= key_next;
      acq_reg <= acq_next;
      ack_pend_reg <= ack_pend_next;
    end
  end

  // ==========================================================
  // pin drivers and device-side outputs
  always_comb begin
    // mode pin is driven only while acknowledging an swd acquire [R12]
    tms_oen_next = !((mode_reg == dpac_pkg::MODE_SWD) && ack_pend_reg);
    tms_out_next = 1'b0;
    tdo_out_next = t.tdo;
    tdo_oen_next = !(t.en && t.tdo_en);
    // trace viewer rides on the data-out pin, only beside swd
    if (mode_reg == dpac_pkg::MODE_SWD && ctrl_reg[dpac_pkg::CTRL_SWV_EN]) begin
      tdo_out_next = trace_viewer_output_i;
      tdo_oen_next = 1'b0;
    end
    gpio_next = !port_on; // [R8]
    doc_next = ctrl_reg[dpac_pkg::CTRL_DOC_EN] && !lock_reg; // lockout gates it too [R1] [R3]
    srst_next = t.rst_req && port_on && (dps_reg != dpac_pkg::DPS_OFF); // [R10]
    case (mode_reg) // [R4]
      dpac_pkg::MODE_JTAG4: pins_next = dpac_pkg::PINS_JTAG4;
      dpac_pkg::MODE_JTAG5: pins_next = dpac_pkg::PINS_JTAG5;
      dpac_pkg::MODE_SWD: pins_next = ctrl_reg[dpac_pkg::CTRL_SWV_EN] ?
                                      dpac_pkg::PINS_SWD_SWV : dpac_pkg::PINS_SWD;
      default: pins_next = dpac_pkg::PINS_NONE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tms_out_reg <= 1'b0;
      tms_oen_reg <= 1'b1;
      tdo_out_reg <= 1'b0;
      tdo_oen_reg <= 1'b1;
      gpio_reg <= 1'b1;
      doc_reg <= 1'b0;
      srst_reg <= 1'b0;
      pins_reg <= dpac_pkg::PINS_NONE;
    end else begin
      tms_out_reg <= tms_out_next;
      tms_oen_reg <= tms_oen_next;
      tdo_out_reg <= tdo_out_next;
      tdo_oen_reg <= tdo_oen_next;
      gpio_reg <= gpio_next;
      doc_reg <= doc_next;
      srst_reg <= srst_next;
      pins_reg <= pins_next;
    end
  end

  // ==========================================================
  // wishbone slave: answer one cycle after the strobe, unmapped reads zero
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;

  always_comb begin
    ctrl_next = ctrl_reg;
    ack_next = wb_req;
    rdat_next = rdat_reg;
    if (wb_req && wb_we_i && wb_adr_i == dpac_pkg::REG_CTRL && wb_sel_i[0]) begin
      // only firmware can turn the debug circuits on [R1] [R2]
      ctrl_next = wb_dat_i[2:0];
    end
    if (wb_req && !wb_we_i) begin
      rdat_next = 32'h00000000;
      case (wb_adr_i)
        dpac_pkg::REG_CTRL: rdat_next[2:0] = ctrl_reg;
        dpac_pkg::REG_STAT: begin
          rdat_next[dpac_pkg::STAT_MODE_LSB +: 2] = mode_reg;
          rdat_next[dpac_pkg::STAT_LOCK] = lock_reg;
          rdat_next[dpac_pkg::STAT_ACQ] = acq_reg;
          rdat_next[dpac_pkg::STAT_WIN] = win_open;
          rdat_next[dpac_pkg::STAT_DPS_LSB +: 2] = dps_reg;
        end
        dpac_pkg::REG_IDENT: rdat_next = dpac_pkg::IDENT_VAL;
        default: rdat_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= dpac_pkg::CTRL_RST;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  // registered, so the enable lags the write by one cycle [R3]
  assign debug_on_chip_circuits_o = doc_reg;
  assign tms_o = tms_out_reg;
  assign tms_oe_n_o = tms_oen_reg;
  assign tdo_o = tdo_out_reg;
  assign tdo_oe_n_o = tdo_oen_reg;
  assign gpio_release_o = gpio_reg;
  assign pins_used_o = pins_reg;
  assign sys_reset_req_o = srst_reg;

  // ==========================================================
  // checks
  a_doc_off_reset: assert property (@(posedge clk_i) // [R1]
    rst_i |=> !debug_on_chip_circuits_o)
    else $error("debug circuits on after reset");

  a_doc_fw_only: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    $rose(ctrl_reg[0]) |-> $past(wb_req && wb_we_i && wb_dat_i[0]))
    else $error("debug enable set without a firmware write");

  a_lock_blocks: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (init_reg && lock_reg) |-> ##1 (!port_on && tms_oe_n_o && !sys_reset_req_o))
    else $error("port active under lockout");

  a_pins_used: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (mode_reg == dpac_pkg::MODE_SWD && ctrl_reg[2] && $stable(mode_reg) && $stable(ctrl_reg))
    |=> (pins_used_o == dpac_pkg::PINS_SWD_SWV))
    else $error("swd with trace viewer does not use three pins");

  a_default_jtag4: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (!init_reg && debug_port_select_setting_i == dpac_pkg::DPS_JTAG4 && !lockout_i)
    |=> (mode_reg == dpac_pkg::MODE_JTAG4) ##1 tms_oe_n_o)
    else $error("default setting did not give 4-wire with input-only mode pin");

  a_rst_gated: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    sys_reset_req_o |-> ($past(port_on) && dps_reg != dpac_pkg::DPS_OFF))
    else $error("port reset while ports disabled");

  a_acq_window: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    $rose(acq_reg) |-> $past(win_reg) < dpac_pkg::ACQ_CYC_W)
    else $error("swd taken outside the window");

  a_gpio_release: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    (init_reg && ctrl_reg[1]) |-> ##2 gpio_release_o)
    else $error("pins not released after port disable");

  a_tms_drive: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    !tms_oe_n_o |-> $past(mode_reg == dpac_pkg::MODE_SWD))
    else $error("mode pin driven outside swd");
endmodule

// ### bench/dpac_host.sv
// host debugger model that drives the link pins of the port
`timescale 1ns/100ps
module dpac_host (
  // clock
  input wire logic clk_i,
  // link pins, four or five used by the scan port
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tms_oe_n_o,
  output logic tdi_o,
  output logic trst_n_o
);
  // ==========================================================
  // bit timing
  localparam int HALF = 10; // 6.25 MHz, below 8 MHz and a twentieth of clk
  // pins idle with tck low, test reset released
  initial begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tms_oe_n_o = 1'h0;
    tdi_o = 1'h0;
    trst_n_o = 1'h1;
  end
  // one tck period; tdo is taken just before the rise
  task automatic bit_io(input logic m, input logic d, output logic q);
    tms_o <= m;
    tdi_o <= d;
    repeat (HALF) @(posedge clk_i);
    q = tdo_i;
    tck_o <= 1'h1;
    repeat (HALF) @(posedge clk_i);
    tck_o <= 1'h0;
  endtask
  // ==========================================================
  // tap reset by mode-pin ones, then idle
  task automatic tap_reset();
    logic q;
    repeat (dpac_pkg::TLR_TMS_ONES) bit_io(1'h1, 1'h0, q);
    bit_io(1'h0, 1'h0, q);
  endtask
  // one ir or dr scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    bit_io(1'h1, 1'h0, q);
    if (ir) bit_io(1'h1, 1'h0, q);
    bit_io(1'h0, 1'h0, q);
    bit_io(1'h0, 1'h0, q);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, din[i], q);
      dout[i] = q;
    end
    bit_io(1'h1, 1'h0, q);
    bit_io(1'h0, 1'h0, q);
  endtask
  // key msb first, then let go of the mode pin for the answer
  task automatic send_key(input logic [15:0] k);
    logic q;
    for (int i = 15; i >= 0; i--) bit_io(k[i], 1'h0, q);
    tms_oe_n_o <= 1'h1;
  endtask
  // one released bit, then drive again; no one-way buffer on tms
  task automatic turn_round();
    logic q;
    bit_io(1'h1, 1'h0, q);
    tms_oe_n_o <= 1'h0;
  endtask
  // test reset pin, honoured only in the five-pin setup
  task automatic set_trst(input logic n);
    trst_n_o <= n;
  endtask
endmodule

// ### bench/dpac_top_tb.sv
// self-checking bench of the debug port access control block
`timescale 1ns/100ps
module dpac_top_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, v;
  logic [1:0] debug_port_select_setting;
  logic lockout, trace, tck, host_tms, host_oe_n, tdi, trst_n;
  logic tms_o, tms_oe_n, tdo, tdo_oe_n, tdo_last, debug_on_chip_circuits, gpio_rel, sysrst;
  logic [2:0] pins;
  logic [7:0] bsr;
  wire tms_w, tdo_w;
  int mismatches, n_checks, n_rst, n0;
  // mode pin: device drive first, pull-up when nobody drives
  assign tms_w = !tms_oe_n ? tms_o : (!host_oe_n ? host_tms : 1'h1);
  assign tdo_w = tdo_oe_n ? ~tdo_last : tdo; // released line shows no stale bit
  // remember tdo and count reset request pulses
  always @(posedge clk_i) begin
    if (!tdo_oe_n) tdo_last <= tdo;
    if (sysrst === 1'h1) n_rst <= n_rst + 1;
  end
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  dpac_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .debug_port_select_setting_i(debug_port_select_setting),
    .lockout_i(lockout), .tck_i(tck), .tms_i(tms_w), .tms_o(tms_o), .tms_oe_n_o(tms_oe_n),
    .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
    .trace_viewer_output_i(trace), .bsr_in_i(bsr), .debug_on_chip_circuits_o(debug_on_chip_circuits),
    .gpio_release_o(gpio_rel), .pins_used_o(pins), .sys_reset_req_o(sysrst));
  dpac_host host (.clk_i(clk_i), .tdo_i(tdo_w), .tck_o(tck), .tms_o(host_tms),
    .tms_oe_n_o(host_oe_n), .tdi_o(tdi), .trst_n_o(trst_n));
  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic do_reset(input logic [1:0] sel, input logic lk);
    @(posedge clk_i);
    rst_i <= 1'h1;
    debug_port_select_setting <= sel;
    lockout <= lk;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end
  // ==========================================================
  // tests
  initial begin
    rst_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, trace, tdo_last, lockout} = '0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    debug_port_select_setting = 2'h0;
    bsr = 8'h96;
    n_rst = 0;
    do_reset(dpac_pkg::DPS_JTAG4, 1'h0);
    check("pins", 32'(pins), 32'(dpac_pkg::PINS_JTAG4));
    check("doc", 32'(debug_on_chip_circuits), 32'h0);
    check("gpio", 32'(gpio_rel), 32'h0);
    check("tms_oe_n", 32'(tms_oe_n), 32'h1);
    wb(1'h0, dpac_pkg::REG_STAT, 32'h0);
    check("stat", rd & 32'hCF, 32'h01);
    wb(1'h0, dpac_pkg::REG_IDENT, 32'h0);
    check("ident", rd, dpac_pkg::IDENT_VAL);
    wb(1'h0, 4'hC, 32'h0);
    check("unmapped", rd, 32'h0);
    wb(1'h1, dpac_pkg::REG_CTRL, 32'h1);
    @(posedge clk_i);
    check("doc", 32'(debug_on_chip_circuits), 32'h1);
    // idcode, boundary capture and reset through the port
    host.tap_reset();
    host.scan(1'h1, 32'(dpac_pkg::IR_IDCODE), 4, v);
    host.scan(1'h0, 32'h0, 32, v);
    check("idcode", v, dpac_pkg::TAP_IDCODE);
    host.scan(1'h1, 32'(dpac_pkg::IR_EXTEST), 4, v);
    host.scan(1'h0, 32'h0, 8, v);
    check("bsr", v, 32'h96);
    n0 = n_rst;
    host.scan(1'h1, 32'(dpac_pkg::IR_DEVRST), 4, v);
    host.scan(1'h0, 32'h1, 1, v);
    check("sysrst", 32'(n_rst - n0), 32'h1);
    // firmware releases the pins; clearing the bit does not bring them back
    wb(1'h1, dpac_pkg::REG_CTRL, 32'h2);
    repeat (3) @(posedge clk_i);
    check("gpio", 32'(gpio_rel), 32'h1);
    check("pins", 32'(pins), 32'h0);
    wb(1'h1, dpac_pkg::REG_CTRL, 32'h0);
    repeat (3) @(posedge clk_i);
    check("gpio", 32'(gpio_rel), 32'h1);
    // ports disabled: no reset through the port
    do_reset(dpac_pkg::DPS_OFF, 1'h0);
    check("pins", 32'(pins), 32'h0);
    n0 = n_rst;
    host.tap_reset();
    host.scan(1'h1, 32'(dpac_pkg::IR_DEVRST), 4, v);
    host.scan(1'h0, 32'h1, 1, v);
    check("sysrst", 32'(n_rst - n0), 32'h0);
    do_reset(dpac_pkg::DPS_JTAG5, 1'h0);
    check("pins", 32'(pins), 32'(dpac_pkg::PINS_JTAG5));
    wb(1'h0, dpac_pkg::REG_STAT, 32'h0);
    check("stat", rd & 32'hCF, 32'h42);
    // test reset pin brings the instruction back to idcode
    host.tap_reset();
    host.scan(1'h1, 32'(dpac_pkg::IR_EXTEST), 4, v);
    host.set_trst(1'h0);
    repeat (8) @(posedge clk_i);
    host.set_trst(1'h1);
    repeat (4) @(posedge clk_i);
    host.bit_io(1'h0, 1'h0, v[0]);
    host.scan(1'h0, 32'h0, 32, v);
    check("trst", v, dpac_pkg::TAP_IDCODE);
    // permanent lockout
    do_reset(dpac_pkg::DPS_JTAG4, 1'h1);
    check("pins", 32'(pins), 32'h0);
    wb(1'h1, dpac_pkg::REG_CTRL, 32'h1);
    @(posedge clk_i);
    check("doc", 32'(debug_on_chip_circuits), 32'h0);
    wb(1'h0, dpac_pkg::REG_STAT, 32'h0);
    check("lock", 32'(rd[3]), 32'h1);
    // key after the window is ignored, key inside it acquires swd
    do_reset(dpac_pkg::DPS_SWD, 1'h0);
    repeat (1100) @(posedge clk_i);
    host.send_key(dpac_pkg::ACQ_KEY);
    host.turn_round();
    wb(1'h0, dpac_pkg::REG_STAT, 32'h0);
    check("late", 32'(rd[5:4]), 32'h0);
    check("late pins", 32'(pins), 32'(dpac_pkg::PINS_NONE));
    do_reset(dpac_pkg::DPS_SWD, 1'h0);
    host.send_key(dpac_pkg::ACQ_KEY);
    check("tms_oe_n", 32'(tms_oe_n), 32'h0);
    host.turn_round();
    wb(1'h0, dpac_pkg::REG_STAT, 32'h0);
    check("stat", rd & 32'h1F, 32'h13);
    check("pins", 32'(pins), 32'(dpac_pkg::PINS_SWD));
    // trace viewer on tdo in swd mode
    wb(1'h1, dpac_pkg::REG_CTRL, 32'h4);
    repeat (3) @(posedge clk_i);
    check("pins", 32'(pins), 32'(dpac_pkg::PINS_SWD_SWV));
    for (int t = 1; t >= 0; t--) begin
      trace <= t[0];
      repeat (6) @(posedge clk_i);
      check("tdo", 32'(tdo), 32'(t));
    end
    give_verdict();
  end
endmodule
